// ### hw/head_fault_flag.sv
// Head fault flag block with AXI4-Lite programming registers
`timescale 1ns/100ps
module head_fault_flag
  import fault_flag_pkg::*;
#(
  parameter int HOLD_CYCLES = fault_flag_pkg::RELEASE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog detector outputs
  input wire logic ref_resistor_fault,
  input wire logic vcc_low,
  input wire logic vcc_wd_low,
  input wire logic write_data_slow,
  input wire logic write_head_open,
  input wire logic unselected_head_biased,
  input wire logic thermal_asperity_detector,
  // Open-collector flag, analog controls and interrupt
  output logic head_fault_flag_o,
  output logic head_fault_flag_oe,
  output logic write_current_inhibit,
  output logic [1:0] asperity_threshold,
  output logic irq
);
  import fault_flag_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] config_q;
  logic [7:0] power_q;
  logic [7:0] test_q;
  logic [7:0] compcap_q;
  logic [7:0] servo_q;
  logic [7:0] control_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;

  // AXI handshake state
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_val;

  // Mode and detector state
  mode_e mode;
  logic write_q;
  logic [$clog2(BLANK_CYCLES + 1)-1:0] blank_q;
  logic blanking;
  logic fault_raw;
  logic fault_held;
  logic fault_held_q;
  logic flag_low;
  logic [7:0] irq_event;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data taken in either order; each ready drops when taken, returns after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= s_axi_awready ? !s_axi_awvalid : (!aw_held_q && (!s_axi_bvalid || s_axi_bready));
      s_axi_wready <= s_axi_wready ? !s_axi_wvalid : (!w_held_q && (!s_axi_bvalid || s_axi_bready));
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  // Address decode for writes; a write to the read-only status register still answers OKAY and is ignored
  always_comb begin
    case (aw_addr_q)
      OFS_CONFIG, OFS_POWER, OFS_TEST, OFS_COMPCAP, OFS_SERVO, OFS_CONTROL,
      OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Programming registers
  // ****************************************
  // Only defined bits take data; byte lane 0 carries every field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= REG_RESET;
      power_q <= REG_RESET;
      test_q <= REG_RESET;
      compcap_q <= REG_RESET;
      servo_q <= REG_RESET;
      control_q <= REG_RESET;
      irq_mask_q <= REG_RESET;
    end else if (ce && wr_go && w_lane_q) begin
      case (aw_addr_q)
        OFS_CONFIG: config_q <= w_data_q & MASK_CONFIG;
        OFS_POWER: power_q <= w_data_q & MASK_POWER;
        OFS_TEST: test_q <= w_data_q & MASK_TEST;
        OFS_COMPCAP: compcap_q <= w_data_q & MASK_COMPCAP;
        OFS_SERVO: servo_q <= w_data_q & MASK_SERVO;
        OFS_CONTROL: control_q <= w_data_q & MASK_CONTROL;
        OFS_IRQ_MASK: irq_mask_q <= w_data_q & MASK_IRQ;
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_go = s_axi_arvalid && s_axi_arready;
  // Read mux; status shows live flag, detector and mode state
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_CONFIG: rd_val = config_q;
      OFS_POWER: rd_val = power_q;
      OFS_TEST: rd_val = test_q;
      OFS_COMPCAP: rd_val = compcap_q;
      OFS_SERVO: rd_val = servo_q;
      OFS_CONTROL: rd_val = control_q;
      OFS_STATUS: rd_val = {1'b0, 3'(mode), write_current_inhibit, blanking, fault_held_q, head_fault_flag_oe};
      OFS_IRQ_STAT: rd_val = irq_stat_q;
      OFS_IRQ_MASK: rd_val = irq_mask_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data answers one cycle after the address is taken; ready rests until it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (ce) begin
      s_axi_arready <= s_axi_arready ? !s_axi_arvalid : (!s_axi_rvalid || s_axi_rready);
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Operating mode decode
  // ****************************************
  // Power-off first, then servo: it overrides every other mode while writing
  always_comb begin
    if (power_q[1:0] != PWR_ACTIVE) begin
      mode = MODE_OFF;
    end else if (control_q[CTRL_WRITE_GATE] && servo_q[1:0] != 2'h0) begin
      mode = MODE_SERVO;
    end else if (control_q[CTRL_ANALOG_TEST]) begin
      mode = MODE_ANALOG;
    end else if (test_q[TEST_ASPERITY]) begin
      mode = MODE_ASPERITY;
    end else if (test_q[2:0] != TEST_NORMAL) begin
      mode = MODE_TEST_HIGH;
    end else if (control_q[CTRL_WRITE_GATE]) begin
      mode = MODE_WRITE;
    end else begin
      mode = MODE_READ;
    end
  end

  // ****************************************
  // Write entry blanking
  // ****************************************
  // Switching transient would look like an open head, so detection waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_q <= 1'b0;
      blank_q <= '0;
    end else if (ce) begin
      write_q <= (mode == MODE_WRITE);
      if (mode == MODE_WRITE && !write_q) begin
        blank_q <= ($bits(blank_q))'(BLANK_CYCLES);
      end else if (blank_q != '0) begin
        blank_q <= blank_q - ($bits(blank_q))'(1);
      end
    end
  end

  assign blanking = (mode == MODE_WRITE) && (!write_q || blank_q != '0);

  // ****************************************
  // Shared fault detector
  // ****************************************
  // One raw fault term feeds a single hold counter for every mode
  always_comb begin
    case (mode)
      MODE_READ: fault_raw = ref_resistor_fault || vcc_low || vcc_wd_low;
      MODE_WRITE: fault_raw = !blanking && (ref_resistor_fault || vcc_low || vcc_wd_low
                              || write_data_slow || write_head_open || unselected_head_biased);
      MODE_ASPERITY: fault_raw = thermal_asperity_detector;
      default: fault_raw = 1'b0;
    endcase
  end

  fault_hold #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .fault_raw(fault_raw),
    .held(fault_held)
  );

  // ****************************************
  // Flag level per mode
  // ****************************************
  // Low means the open-collector transistor conducts
  always_comb begin
    case (mode)
      MODE_OFF: flag_low = 1'b0;
      MODE_READ: flag_low = !config_q[CFG_FAULT_REPORT_SELECT] && fault_held;
      MODE_WRITE: begin
        if (config_q[CFG_FAULT_REPORT_SELECT]) begin
          flag_low = 1'b1;
        end else if (blanking) begin
          flag_low = 1'b1;
        end else begin
          flag_low = !fault_held;
        end
      end
      MODE_ASPERITY: flag_low = fault_held;
      MODE_SERVO: flag_low = 1'b1;
      MODE_ANALOG: flag_low = 1'b0;
      MODE_TEST_HIGH: flag_low = 1'b0;
      default: flag_low = 1'b0;
    endcase
  end

  // Registered pin drive; never drives high, pull-up is external
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_fault_flag_o <= 1'b0;
      head_fault_flag_oe <= 1'b0;
    end else if (ce) begin
      head_fault_flag_o <= 1'b0;
      head_fault_flag_oe <= flag_low;
    end
  end

  // Write current inhibit and asperity threshold select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_current_inhibit <= 1'b0;
      asperity_threshold <= 2'h0;
    end else if (ce) begin
      write_current_inhibit <= (mode == MODE_WRITE) && !blanking && fault_held
                               && !config_q[CFG_WRITE_INHIBIT_ENABLE];
      asperity_threshold <= {compcap_q[COMPCAP_THRESHOLD], test_q[TEST_LSB]};
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_event = 8'h00;
    irq_event[IRQ_FAULT_SET] = fault_held && !fault_held_q;
    irq_event[IRQ_FAULT_CLEAR] = !fault_held && fault_held_q;
    irq_event[IRQ_ASPERITY] = (mode == MODE_ASPERITY) && thermal_asperity_detector;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= REG_RESET;
      fault_held_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      fault_held_q <= fault_held;
      if (wr_go && w_lane_q && aw_addr_q == OFS_IRQ_STAT) begin
        irq_stat_q <= ((irq_stat_q & ~w_data_q) | irq_event) & MASK_IRQ;
      end else begin
        irq_stat_q <= (irq_stat_q | irq_event) & MASK_IRQ;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule

// ### hw/fault_flag_pkg.sv
// Package: register map, field layout and timing constants of the fault flag block
package fault_flag_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_POWER = 8'h04;
  localparam logic [7:0] OFS_TEST = 8'h08;
  localparam logic [7:0] OFS_COMPCAP = 8'h0c;
  localparam logic [7:0] OFS_SERVO = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // Writable bits of each register; the rest are unused and read as zero
  localparam logic [7:0] MASK_CONFIG = 8'h0a;
  localparam logic [7:0] MASK_POWER = 8'h03;
  localparam logic [7:0] MASK_TEST = 8'h07;
  localparam logic [7:0] MASK_COMPCAP = 8'h07;
  localparam logic [7:0] MASK_SERVO = 8'h03;
  localparam logic [7:0] MASK_CONTROL = 8'h03;
  localparam logic [7:0] MASK_IRQ = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int CFG_WRITE_INHIBIT_ENABLE = 1;
  localparam int CFG_FAULT_REPORT_SELECT = 3;
  localparam int TEST_ASPERITY = 2;
  localparam int TEST_LSB = 0;
  localparam int COMPCAP_THRESHOLD = 2;
  localparam int CTRL_WRITE_GATE = 0;
  localparam int CTRL_ANALOG_TEST = 1;
  localparam int IRQ_FAULT_SET = 0;
  localparam int IRQ_FAULT_CLEAR = 1;
  localparam int IRQ_ASPERITY = 2;
  // Encodings
  localparam logic [1:0] PWR_SLEEP = 2'h0;
  localparam logic [1:0] PWR_ACTIVE = 2'h3;
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int RELEASE_MIN_NS = 500;
  localparam int RELEASE_MAX_NS = 1000;
  localparam int OPEN_DETECT_NS = 15;
  // Least time rounds up
  localparam int RELEASE_CYCLES = (RELEASE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RELEASE_MAX_CYCLES = (RELEASE_MAX_NS * CLK_MHZ) / 1000;
  localparam int BLANK_RAW = (OPEN_DETECT_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYCLES = (BLANK_RAW < 1) ? 1 : BLANK_RAW;
  typedef enum logic [2:0] {
    MODE_OFF, MODE_READ, MODE_WRITE, MODE_TEST_HIGH, MODE_ASPERITY, MODE_SERVO, MODE_ANALOG
  } mode_e;
endpackage

// ### hw/fault_hold.sv
// Retriggerable hold counter that stretches a fault until its release delay passes
`timescale 1ns/100ps
module fault_hold #(
  parameter int HOLD_CYCLES = 25
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic fault_raw,
  output logic held
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);
  logic [CW-1:0] count_q;

  // Restarted by each detected fault, counts down after the last one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (ce) begin
      if (fault_raw) begin
        count_q <= HOLD_LOAD;
      end else if (count_q != '0) begin
        count_q <= count_q - CW'(1);
      end
    end
  end

  assign held = fault_raw || (count_q != '0);
endmodule

// ### sim/fault_line_sense.sv
// Controller side of the shared open-collector fault line
`timescale 1ns/100ps
module fault_line_sense (
  input wire logic flag_o,
  input wire logic flag_oe,
  output logic line
);
  // Pull-up wins unless some amplifier pulls the wire low
  assign line = (flag_oe && !flag_o) ? 1'b0 : 1'b1;
endmodule

// ### sim/head_fault_flag_props.sv
// Port-level checker for the head fault flag block
`timescale 1ns/100ps
module head_fault_flag_props
  import fault_flag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic head_fault_flag_o,
  input wire logic head_fault_flag_oe,
  input wire logic irq
);
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flag_never_high: assert property (head_fault_flag_o == 1'b0)
    else $error("fault flag driven high");
  // Reset must leave the line released even though disable is normally reset
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !head_fault_flag_oe && !s_axi_bvalid && !irq)
    else $error("state not cleared by reset");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unused_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unused read bits set");
  // Main scenarios seen
  c_flag_pull: cover property ($rose(head_fault_flag_oe));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind head_fault_flag head_fault_flag_props props (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .head_fault_flag_o(head_fault_flag_o),
  .head_fault_flag_oe(head_fault_flag_oe), .irq(irq));

// ### sim/head_fault_flag_test.sv
// Register and fault flag tests for the head fault flag block
`timescale 1ns/100ps
module head_fault_flag_test;
  import fault_flag_pkg::*;
  // Full release delay, so the window is judged in real time
  localparam int HOLD = RELEASE_CYCLES;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, flag_o, flag_oe, inhibit, irq, line;
  logic [1:0] bresp, rresp, thr;
  logic [31:0] rdata;
  logic [6:0] det = 0;
  int bad_count = 0, tests_run = 0;
  logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
  logic [7:0] msk[8] = '{8'h0a, 8'h03, 8'h07, 8'h07, 8'h03, 8'h03, 8'h00, 8'h07};
  head_fault_flag #(.HOLD_CYCLES(HOLD)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ref_resistor_fault(det[0]), .vcc_low(det[1]), .vcc_wd_low(det[2]),
    .write_data_slow(det[3]), .write_head_open(det[4]), .unselected_head_biased(det[5]),
    .thermal_asperity_detector(det[6]), .head_fault_flag_o(flag_o), .head_fault_flag_oe(flag_oe),
    .write_current_inhibit(inhibit), .asperity_threshold(thr), .irq(irq));
  fault_line_sense ctl (.flag_o(flag_o), .flag_oe(flag_oe), .line(line));
  // ****************
  // Tasks
  // ****************
  // 50 MHz clock
  always #10 aclk = ~aclk;
  task automatic results;
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is judged mid-cycle so the handshake edge is known before it comes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awready && !da;
      tw = wready && !dw;
      @(posedge aclk);
      if (ta) begin da = 1; awvalid <= 0; end
      if (tw) begin dw = 1; wvalid <= 0; end
    end
    do @(negedge aclk); while (!bvalid);
    ck(bresp, er);
    @(posedge aclk);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    ck(rdata, e);
    ck(rresp, er);
    @(posedge aclk);
    rready <= 0;
  endtask
  // Program one mode, apply detector levels, then judge the wire
  task automatic fc(input logic [7:0] c, p, t, k, s, input logic [6:0] d, input logic e);
    @(posedge aclk) det <= 0;
    wr(OFS_CONFIG, c, RESP_OKAY); wr(OFS_POWER, p, RESP_OKAY); wr(OFS_TEST, t, RESP_OKAY);
    wr(OFS_SERVO, s, RESP_OKAY); wr(OFS_CONTROL, k, RESP_OKAY);
    det <= d;
    repeat (HOLD + 4) @(posedge aclk);
    @(negedge aclk) ck(line, e);
  endtask
  // ****************
  // Tests
  // ****************
  // Watchdog sized well past the expected run
  initial begin
    #400000;
    bad_count++;
    results();
  end
  initial begin
    int n;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 10; i++) rd(8'(4 * i), 0, (i < 9) ? RESP_OKAY : RESP_SLVERR);
    for (int i = 0; i < 8; i++) wr(ofs[i], 32'hffffffff, RESP_OKAY);
    for (int i = 0; i < 8; i++) rd(ofs[i], {24'h0, msk[i]}, RESP_OKAY);
    for (int i = 0; i < 8; i++) wr(ofs[i], 32'h0, RESP_OKAY);
    wr(8'h24, 32'h1, RESP_SLVERR);
    rd(8'h24, 0, RESP_SLVERR);
    wr(OFS_TEST, 1, RESP_OKAY); wr(OFS_COMPCAP, 4, RESP_OKAY);
    @(negedge aclk) ck(thr, 2'b11);
    wr(OFS_TEST, 0, RESP_OKAY);
    @(negedge aclk) ck(thr, 2'b10);
    for (int p = 0; p < 3; p++) fc(0, p, 0, 0, 0, 7'h03, 1);
    fc(8, 3, 0, 0, 0, 7'h03, 1);
    for (int i = 0; i < 3; i++) fc(0, 3, 0, 0, 0, 7'(1 << i), 0);
    // Release window after the last fault goes away
    @(posedge aclk) det <= 0;
    n = 0;
    do begin @(negedge aclk); n++; end while (!line && n < 3 * HOLD);
    ck(n * 1000 / CLK_MHZ >= RELEASE_MIN_NS && n * 1000 / CLK_MHZ <= RELEASE_MAX_NS, 1);
    fc(0, 3, 3, 0, 0, 7'h03, 1);
    fc(0, 3, 4, 0, 0, 7'h00, 1);
    fc(8, 3, 5, 0, 0, 7'h40, 0);
    fc(0, 3, 0, 1, 3, 7'h10, 0);
    fc(8, 3, 0, 1, 0, 7'h10, 0);
    fc(0, 3, 0, 1, 0, 7'h00, 0);
    for (int i = 0; i < 6; i++) fc(0, 3, 0, 1, 0, 7'(1 << i), 1);
    ck(inhibit, 1);
    fc(0, 3, 0, 3, 0, 7'h10, 1);
    fc(0, 3, 0, 2, 0, 7'h02, 1);
    // Masked event first, then unmask and clear
    wr(OFS_IRQ_MASK, 0, RESP_OKAY);
    fc(0, 3, 0, 0, 0, 7'h02, 0);
    ck(irq, 0);
    wr(OFS_IRQ_MASK, 1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    @(negedge aclk) ck(irq, 1);
    wr(OFS_IRQ_STAT, 7, RESP_OKAY);
    repeat (2) @(posedge aclk);
    @(negedge aclk) ck(irq, 0);
    // Clock enable low freezes the hold counter, so the fault stays on the wire
    @(posedge aclk) ce <= 0;
    det <= 0;
    repeat (HOLD + 4) @(posedge aclk);
    @(negedge aclk) ck(line, 0);
    @(posedge aclk) ce <= 1;
    repeat (HOLD + 4) @(posedge aclk);
    @(negedge aclk) ck(line, 1);
    results();
  end
endmodule
